/* hw/ovc_defines.svh */
// register offsets, field positions, reset values and timing counts
// for the line-output volume and mute control block
`ifndef OVC_DEFINES_SVH
`define OVC_DEFINES_SVH

`define OVC_ADDR_W 5
`define OVC_DATA_W 8

`define OVC_REG_ATTEN 5'h0a
`define OVC_REG_OUTMUTE 5'h0b
`define OVC_REG_MONOMUTE 5'h0c
`define OVC_REG_DIGCTRL 5'h13

// attenuation register: left code high nibble, right code low nibble
`define OVC_ATTEN_L_MSB 7
`define OVC_ATTEN_L_LSB 4
`define OVC_ATTEN_R_MSB 3
`define OVC_ATTEN_R_LSB 0
// output mute register
`define OVC_RIGHT_ONE_BIT 0
`define OVC_LEFT_ONE_BIT 1
`define OVC_TOGGLE_STATE_BIT 7
// mono mute register
`define OVC_RIGHT_TWO_BIT 0
`define OVC_LEFT_TWO_BIT 1
`define OVC_LEFT_DAC_BIT 2
`define OVC_RIGHT_DAC_BIT 3
`define OVC_BEEP_BIT 4
// digital control register
`define OVC_BTN_EN_BIT 2
`define OVC_POT_EN_BIT 3
`define OVC_POT_CODE_MSB 7
`define OVC_POT_CODE_LSB 4

`define OVC_ATTEN_RST 8'h00
`define OVC_OUTMUTE_RST 2'h0
`define OVC_MONOMUTE_RST 5'h10
`define OVC_CODE_MAX 4'hf
`define OVC_CODE_MIN 4'h0

// status stream frame bit positions of the inverted button levels
`define OVC_STAT_MUTE_POS 21
`define OVC_STAT_DOWN_POS 22
`define OVC_STAT_UP_POS 23

`define OVC_CLK_HZ 50000000
`define OVC_POT_PERIOD_MS 100
`define OVC_POT_PERIOD_CYC (`OVC_POT_PERIOD_MS * (`OVC_CLK_HZ / 1000))
`define OVC_ZC_TIMEOUT_FRAMES 512
`define OVC_DEBOUNCE_FRAMES 4
// half a code step of hysteresis, in pot level counts
`define OVC_POT_HYST 9'h008
`define OVC_POT_STEP 9'h010

`endif

/* hw/ovc_pkg.sv */
// types shared by the volume and mute control block
// assumes ovc_defines.svh for numeric constants
package ovc_pkg;

   typedef enum logic [1:0]
   {
      OVC_BTN_UP = 2'b00,
      OVC_BTN_DOWN = 2'b01,
      OVC_BTN_MUTE = 2'b10
   } ovc_btn_t;

endpackage

/* hw/ovc_volume_mute.sv */
// line-output volume and mute control: buttons, pot, zero-cross apply
// assumes inputs synchronous to CORE_CLK_IN, FRAME_IN one pulse per frame
//
// Local design decisions: the plain strobed port and the register addresses.
`include "ovc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ovc_volume_mute
#(
   parameter int unsigned POT_UPDATE_CYCLES = `OVC_POT_PERIOD_CYC,
   parameter int unsigned DEBOUNCE_FRAMES = `OVC_DEBOUNCE_FRAMES
)
(
   input wire logic CORE_CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic [`OVC_ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [`OVC_DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [`OVC_DATA_W-1:0] REG_RDATA_OUT,
   input wire logic VOLUME_INCREASE_BUTTON_N_IN,
   input wire logic VOLUME_DECREASE_BUTTON_N_IN,
   input wire logic MUTE_TOGGLE_BUTTON_N_IN,
   input wire logic [7:0] VOLUME_POT_INPUT_IN,
   input wire logic FRAME_IN,
   input wire logic ZERO_CROSS_IN,
   output logic [3:0] LEFT_ATTEN_OUT,
   output logic [3:0] RIGHT_ATTEN_OUT,
   output logic RIGHT_OUT_ONE_MUTE_OUT,
   output logic LEFT_OUT_ONE_MUTE_OUT,
   output logic RIGHT_OUT_TWO_MUTE_OUT,
   output logic LEFT_OUT_TWO_MUTE_OUT,
   output logic LEFT_DAC_MONO_MUTE_OUT,
   output logic RIGHT_DAC_MONO_MUTE_OUT,
   output logic BEEP_PATH_MUTE_OUT,
   output logic [2:0] BUTTON_STATUS_OUT
);

   localparam int unsigned POT_CNT_W = $clog2(POT_UPDATE_CYCLES + 1);
   localparam int unsigned DB_CNT_W = $clog2(DEBOUNCE_FRAMES + 1);
   localparam logic [8:0] ZC_LAST = 9'(`OVC_ZC_TIMEOUT_FRAMES - 1);

   logic [3:0] atten_l, atten_r, pot_code;
   logic [1:0] out_mute;
   logic [4:0] mono_mute;
   logic button_volume_enable, pot_volume_enable, toggle_mute_state, pot_tick, gain_pending;
   logic pot_mode, atten_wr, atten_access, gain_apply;
   logic [POT_CNT_W-1:0] pot_cnt;
   logic [8:0] zc_frames, pot_lo, pot_hi;
   logic [2:0] btn_raw_n, btn_db_n, btn_press, btn_act;

   assign btn_raw_n = {MUTE_TOGGLE_BUTTON_N_IN, VOLUME_DECREASE_BUTTON_N_IN, VOLUME_INCREASE_BUTTON_N_IN};
   assign pot_mode = pot_volume_enable;
   assign atten_wr = REG_WR_IN && (REG_ADDR_IN == `OVC_REG_ATTEN);
   assign atten_access = (REG_WR_IN || REG_RD_IN) && (REG_ADDR_IN == `OVC_REG_ATTEN);

   // debounce: per-frame sampling, state moves only after stable run
      for (genvar gi = 0; gi < 3; gi++)
      begin : g_btn
         logic [DB_CNT_W-1:0] db_cnt;
         always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
         begin
            if (!ARST_N_IN)
            begin
               db_cnt <= '0;
               btn_db_n[gi] <= 1'b1;
               btn_press[gi] <= 1'b0;
            end
            else
            begin
               btn_press[gi] <= 1'b0;
               if (btn_raw_n[gi] == btn_db_n[gi])
               begin
                  db_cnt <= '0;
               end
               else if (FRAME_IN)
               begin
                  if (db_cnt == DB_CNT_W'(DEBOUNCE_FRAMES - 1))
                  begin
                     db_cnt <= '0;
                     btn_db_n[gi] <= btn_raw_n[gi];
                     btn_press[gi] <= btn_db_n[gi];
                  end
                  else
                  begin
                     db_cnt <= db_cnt + 1'b1;
                  end
               end
            end
         end
      end

   // a press counts only if no other button is already held
   always_comb
   begin
      btn_act = 3'b000;
      if (btn_press[ovc_pkg::OVC_BTN_UP] && (btn_db_n[2:1] == 2'b11))
      begin
         btn_act[ovc_pkg::OVC_BTN_UP] = 1'b1;
      end
      else if (btn_press[ovc_pkg::OVC_BTN_DOWN] && btn_db_n[ovc_pkg::OVC_BTN_UP] && btn_db_n[ovc_pkg::OVC_BTN_MUTE])
      begin
         btn_act[ovc_pkg::OVC_BTN_DOWN] = 1'b1;
      end
      else if (btn_press[ovc_pkg::OVC_BTN_MUTE] && (btn_db_n[1:0] == 2'b11))
      begin
         btn_act[ovc_pkg::OVC_BTN_MUTE] = 1'b1;
      end
   end

   // hysteresis window around the current code, half a step each side
   assign pot_lo = {1'b0, pot_code, 4'h0};
   assign pot_hi = pot_lo + `OVC_POT_STEP + `OVC_POT_HYST;

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         pot_code <= `OVC_CODE_MIN;
      end
      else if ((({1'b0, VOLUME_POT_INPUT_IN} + `OVC_POT_HYST) < pot_lo) ||
               ({1'b0, VOLUME_POT_INPUT_IN} >= pot_hi))
      begin
         pot_code <= VOLUME_POT_INPUT_IN[7:4];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         pot_cnt <= '0;
         pot_tick <= 1'b0;
      end
      else
      begin
         pot_tick <= 1'b0;
         if (pot_cnt == POT_CNT_W'(POT_UPDATE_CYCLES - 1))
         begin
            pot_cnt <= '0;
            pot_tick <= 1'b1;
         end
         else
         begin
            pot_cnt <= pot_cnt + 1'b1;
         end
      end
   end

   // attenuation register: bus, pot or buttons
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         {atten_l, atten_r} <= `OVC_ATTEN_RST;
      end
      else if (pot_mode)
      begin
         if (pot_tick)
         begin
            atten_l <= pot_code;
            atten_r <= pot_code;
         end
      end
      else if (atten_wr)
      begin
         atten_l <= REG_WDATA_IN[`OVC_ATTEN_L_MSB:`OVC_ATTEN_L_LSB];
         atten_r <= REG_WDATA_IN[`OVC_ATTEN_R_MSB:`OVC_ATTEN_R_LSB];
      end
      else if (button_volume_enable && btn_act[ovc_pkg::OVC_BTN_UP])
      begin
         // louder means less attenuation; clamp at the ends
         atten_l <= (atten_l == `OVC_CODE_MIN) ? atten_l : atten_l - 1'b1;
         atten_r <= (atten_r == `OVC_CODE_MIN) ? atten_r : atten_r - 1'b1;
      end
      else if (button_volume_enable && btn_act[ovc_pkg::OVC_BTN_DOWN])
      begin
         atten_l <= (atten_l == `OVC_CODE_MAX) ? atten_l : atten_l + 1'b1;
         atten_r <= (atten_r == `OVC_CODE_MAX) ? atten_r : atten_r + 1'b1;
      end
   end

   // mode bits only select sources; register contents stay put
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         button_volume_enable <= 1'b0;
         pot_volume_enable <= 1'b0;
      end
      else if (REG_WR_IN && (REG_ADDR_IN == `OVC_REG_DIGCTRL))
      begin
         button_volume_enable <= REG_WDATA_IN[`OVC_BTN_EN_BIT];
         pot_volume_enable <= REG_WDATA_IN[`OVC_POT_EN_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         out_mute <= `OVC_OUTMUTE_RST;
         mono_mute <= `OVC_MONOMUTE_RST;
      end
      else
      begin
         if (REG_WR_IN && (REG_ADDR_IN == `OVC_REG_OUTMUTE))
         begin
            out_mute <= REG_WDATA_IN[1:0];
         end
         if (REG_WR_IN && (REG_ADDR_IN == `OVC_REG_MONOMUTE))
         begin
            mono_mute <= REG_WDATA_IN[4:0];
         end
      end
   end

   // toggle sits beside the mute bits so their stored values survive
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         toggle_mute_state <= 1'b1;
      end
      else if (button_volume_enable && btn_act[ovc_pkg::OVC_BTN_MUTE])
      begin
         toggle_mute_state <= ~toggle_mute_state;
      end
   end

   // zero-cross gain apply with frame timeout
   assign gain_apply = gain_pending && (ZERO_CROSS_IN || (FRAME_IN && (zc_frames == ZC_LAST)));

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         zc_frames <= '0;
      end
      else if (atten_access)
      begin
         zc_frames <= '0;
      end
      else if (FRAME_IN && gain_pending)
      begin
         zc_frames <= (zc_frames == ZC_LAST) ? 9'h000 : zc_frames + 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         gain_pending <= 1'b0;
      end
      else if ({atten_l, atten_r} != {LEFT_ATTEN_OUT, RIGHT_ATTEN_OUT})
      begin
         // a fresh change arriving while applying stays pending
         gain_pending <= 1'b1;
      end
      else if (gain_apply)
      begin
         gain_pending <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         {LEFT_ATTEN_OUT, RIGHT_ATTEN_OUT} <= `OVC_ATTEN_RST;
      end
      else if (gain_apply)
      begin
         LEFT_ATTEN_OUT <= atten_l;
         RIGHT_ATTEN_OUT <= atten_r;
      end
   end

   // 0 = muted; toggle gates only the out and dac feeds
   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         RIGHT_OUT_ONE_MUTE_OUT <= 1'b0;
         LEFT_OUT_ONE_MUTE_OUT <= 1'b0;
         RIGHT_OUT_TWO_MUTE_OUT <= 1'b0;
         LEFT_OUT_TWO_MUTE_OUT <= 1'b0;
         LEFT_DAC_MONO_MUTE_OUT <= 1'b0;
         RIGHT_DAC_MONO_MUTE_OUT <= 1'b0;
         BEEP_PATH_MUTE_OUT <= 1'b1;
      end
      else
      begin
         RIGHT_OUT_ONE_MUTE_OUT <= out_mute[`OVC_RIGHT_ONE_BIT] & toggle_mute_state;
         LEFT_OUT_ONE_MUTE_OUT <= out_mute[`OVC_LEFT_ONE_BIT] & toggle_mute_state;
         RIGHT_OUT_TWO_MUTE_OUT <= mono_mute[`OVC_RIGHT_TWO_BIT] & toggle_mute_state;
         LEFT_OUT_TWO_MUTE_OUT <= mono_mute[`OVC_LEFT_TWO_BIT] & toggle_mute_state;
         LEFT_DAC_MONO_MUTE_OUT <= mono_mute[`OVC_LEFT_DAC_BIT] & toggle_mute_state;
         RIGHT_DAC_MONO_MUTE_OUT <= mono_mute[`OVC_RIGHT_DAC_BIT] & toggle_mute_state;
         BEEP_PATH_MUTE_OUT <= mono_mute[`OVC_BEEP_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         BUTTON_STATUS_OUT <= 3'h0;
      end
      else
      begin
         BUTTON_STATUS_OUT <= ~btn_raw_n;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         REG_RDATA_OUT <= 8'h00;
      end
      else
      begin
         // index 0 is unmapped, so idle cycles read back zero
         case (REG_RD_IN ? REG_ADDR_IN : 5'h00)
            `OVC_REG_ATTEN: REG_RDATA_OUT <= {atten_l, atten_r};
            `OVC_REG_OUTMUTE: REG_RDATA_OUT <= {toggle_mute_state, 5'h00, out_mute};
            `OVC_REG_MONOMUTE: REG_RDATA_OUT <= {3'h0, mono_mute};
            `OVC_REG_DIGCTRL: REG_RDATA_OUT <= {pot_code, pot_volume_enable, button_volume_enable, 2'h0};
            default: REG_RDATA_OUT <= 8'h00;
         endcase
      end
   end

   default clocking ovc_cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);

   sequence mute_press_s;
      button_volume_enable && btn_act[ovc_pkg::OVC_BTN_MUTE];
   endsequence

   toggle_flip_a: assert property (mute_press_s |=> toggle_mute_state != $past(toggle_mute_state))
      else $error("mute press did not flip toggle");
   beep_kept_a: assert property (##1 BEEP_PATH_MUTE_OUT == $past(mono_mute[`OVC_BEEP_BIT]))
      else $error("beep path followed the toggle");
   pot_block_a: assert property (pot_mode && atten_wr && !pot_tick |=> $stable({atten_l, atten_r}))
      else $error("attenuation written in pot mode");
   up_sat_a: assert property (!pot_mode && !atten_wr && button_volume_enable && btn_act[ovc_pkg::OVC_BTN_UP]
                              && atten_l == 4'h0 |=> atten_l == 4'h0)
      else $error("volume up wrapped");
   pot_read_a: assert property (REG_RD_IN && REG_ADDR_IN == `OVC_REG_DIGCTRL |=>
                                REG_RDATA_OUT[7:4] == $past(pot_code))
      else $error("pot code not readable");
   one_button_a: assert property ($onehot0(btn_act))
      else $error("two buttons acted at once");
   status_a: assert property (##1 BUTTON_STATUS_OUT == ~$past(btn_raw_n))
      else $error("button status wrong");

   sequence timeout_s;
      gain_pending && FRAME_IN && zc_frames == ZC_LAST && !atten_access;
   endsequence

   timeout_a: assert property (timeout_s |=> LEFT_ATTEN_OUT == $past(atten_l))
      else $error("gain not applied on timeout");
   zc_hold_a: assert property (!ZERO_CROSS_IN && !(FRAME_IN && zc_frames == ZC_LAST) |=>
                               $stable(LEFT_ATTEN_OUT))
      else $error("gain changed off zero crossing");
   restart_a: assert property (atten_access |=> zc_frames == 9'h000)
      else $error("frame counter not restarted");

endmodule
`default_nettype wire

/* tb/ovc_far_side.sv */
// far-side model: three pushbuttons, pot level and audio frame timing
// assumes one clock shared with the block; the bench says what is held
`timescale 1ns/1ps
`default_nettype none
module ovc_far_side
(
   input wire logic clk_in,
   input wire logic [2:0] hold_in,
   input wire logic [7:0] level_in,
   input wire logic zc_req_in,
   output logic up_n_out,
   output logic down_n_out,
   output logic mute_n_out,
   output logic [7:0] pot_out,
   output logic frame_out,
   output logic zc_out
);
   logic [2:0] cnt = 3'h0;

   // pull-up on released buttons, low while held
   assign up_n_out = ~hold_in[0];
   assign down_n_out = ~hold_in[1];
   assign mute_n_out = ~hold_in[2];
   assign pot_out = level_in;
   // frame every 8 clocks keeps the 512-frame timeout reachable
   assign frame_out = (cnt == 3'h0);

   always_ff @(posedge clk_in)
   begin
      cnt <= cnt + 3'h1;
      // zero crossing mid-frame, never on the frame pulse itself
      zc_out <= zc_req_in && (cnt == 3'h3);
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the volume and mute control block
// assumes the far-side model drives buttons, pot, frames and zero crossings
`include "ovc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [`OVC_ADDR_W-1:0] addr = 5'h00;
   logic [`OVC_DATA_W-1:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [2:0] hold = 3'h0;
   logic [7:0] level = 8'h00;
   logic zc_req = 1'b0;
   wire logic [7:0] rdata;
   wire logic up_n, down_n, mute_n, frame, zc;
   wire logic [7:0] pot;
   wire logic [3:0] l_att, r_att;
   wire logic [6:0] mute;
   wire logic [2:0] status;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [7:0] pot_lvl [4] = '{8'h42, 8'h4c, 8'hff, 8'h00};
   logic [7:0] pot_exp [4] = '{8'h33, 8'h44, 8'hff, 8'h00};

   ovc_far_side u_ovc_far_side (.clk_in(clk), .hold_in(hold), .level_in(level), .zc_req_in(zc_req),
      .up_n_out(up_n), .down_n_out(down_n), .mute_n_out(mute_n), .pot_out(pot), .frame_out(frame),
      .zc_out(zc));

   // short pot period and debounce keep the run brief
   ovc_volume_mute #(.POT_UPDATE_CYCLES(50), .DEBOUNCE_FRAMES(2)) u_ovc_volume_mute (
      .CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .VOLUME_INCREASE_BUTTON_N_IN(up_n),
      .VOLUME_DECREASE_BUTTON_N_IN(down_n), .MUTE_TOGGLE_BUTTON_N_IN(mute_n), .VOLUME_POT_INPUT_IN(pot),
      .FRAME_IN(frame), .ZERO_CROSS_IN(zc), .LEFT_ATTEN_OUT(l_att), .RIGHT_ATTEN_OUT(r_att),
      .RIGHT_OUT_ONE_MUTE_OUT(mute[0]), .LEFT_OUT_ONE_MUTE_OUT(mute[1]), .RIGHT_OUT_TWO_MUTE_OUT(mute[2]),
      .LEFT_OUT_TWO_MUTE_OUT(mute[3]), .LEFT_DAC_MONO_MUTE_OUT(mute[4]),
      .RIGHT_DAC_MONO_MUTE_OUT(mute[5]), .BEEP_PATH_MUTE_OUT(mute[6]), .BUTTON_STATUS_OUT(status));

   initial
   begin
      forever #10 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, msg);
   endtask

   task automatic wait_frames(input int n);
      repeat (n * 8) @(posedge clk);
   endtask

   // hold one button for n frames, then release for five
   task automatic press(input int b, input int n);
      @(posedge clk);
      hold[b] <= 1'b1;
      wait_frames(n);
      if (n >= 3)
         chk({5'h00, status}, 8'h01 << b, "button status");
      @(posedge clk);
      hold[b] <= 1'b0;
      wait_frames(5);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         $display("Error at %0t: run timed out", $time);
         summarize();
      end
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({1'b0, mute}, 8'h40, "reset mutes");
      chk({l_att, r_att}, 8'h00, "reset attenuation");
      rd_chk(5'h0a, 8'h00, "reset attenuation reg");
      rd_chk(5'h0b, 8'h80, "reset out mute reg");
      rd_chk(5'h0c, 8'h10, "reset mono mute reg");
      rd_chk(5'h1f, 8'h00, "unmapped read");
      $display("test reset done");

      wr_reg(5'h0a, 8'h35);
      wait_frames(3);
      chk({l_att, r_att}, 8'h00, "held until zero cross");
      zc_req <= 1'b1;
      wait_frames(1);
      zc_req <= 1'b0;
      wait_frames(1);
      chk({l_att, r_att}, 8'h35, "applied at zero cross");
      wr_reg(5'h0a, 8'h7a);
      wait_frames(300);
      rd_chk(5'h0a, 8'h7a, "pending value");
      wait_frames(300);
      chk({l_att, r_att}, 8'h35, "timeout restarted by access");
      wait_frames(230);
      chk({l_att, r_att}, 8'h7a, "applied after 512 frames");
      $display("test zero cross done");

      wr_reg(5'h13, 8'h04);
      rd_chk(5'h0a, 8'h7a, "kept on mode change");
      rd_chk(5'h0b, 8'h80, "mute kept on mode change");
      press(1, 5);
      rd_chk(5'h0a, 8'h8b, "down step");
      // one-cycle glitch can meet at most one frame pulse
      press(0, 0);
      rd_chk(5'h0a, 8'h8b, "short glitch ignored");
      press(0, 5);
      rd_chk(5'h0a, 8'h7a, "up step");
      wr_reg(5'h0a, 8'hff);
      rd_chk(5'h0a, 8'hff, "bus write in button mode");
      press(1, 5);
      rd_chk(5'h0a, 8'hff, "saturate at max");
      wr_reg(5'h0a, 8'h00);
      press(0, 5);
      rd_chk(5'h0a, 8'h00, "saturate at min");
      wr_reg(5'h0a, 8'h55);
      @(posedge clk);
      hold[0] <= 1'b1;
      wait_frames(4);
      hold[1] <= 1'b1;
      wait_frames(4);
      hold <= 3'h0;
      wait_frames(5);
      rd_chk(5'h0a, 8'h44, "first pressed wins");
      $display("test buttons done");

      // bench never changes the sample rate, so no mute-first step
      wr_reg(5'h0b, 8'h03);
      wr_reg(5'h0c, 8'h1f);
      wait_frames(1);
      chk({1'b0, mute}, 8'h7f, "all unmuted");
      press(2, 5);
      chk({1'b0, mute}, 8'h40, "toggle mutes all but beep");
      rd_chk(5'h0b, 8'h03, "stored mutes kept");
      rd_chk(5'h0c, 8'h1f, "mono mutes kept");
      press(2, 5);
      chk({1'b0, mute}, 8'h7f, "toggle unmutes");
      rd_chk(5'h0b, 8'h83, "toggle state unmuted");
      $display("test mute done");

      level <= 8'h35;
      wr_reg(5'h13, 8'h0c);
      repeat (120) @(posedge clk);
      rd_chk(5'h0a, 8'h33, "pot loaded");
      rd_chk(5'h13, 8'h3c, "pot code readable");
      wr_reg(5'h0a, 8'h99);
      rd_chk(5'h0a, 8'h33, "bus write blocked");
      press(0, 5);
      rd_chk(5'h0a, 8'h33, "button ignored in pot mode");
      for (int i = 0; i < 4; i++)
      begin
         level <= pot_lvl[i];
         repeat (120) @(posedge clk);
         rd_chk(5'h0a, pot_exp[i], "pot code with hysteresis");
      end
      $display("test pot done");
      summarize();
   end
endmodule
`default_nettype wire
